// ### bench/spibf_master.sv
`timescale 1ns/1ps
// External link master, mode 0 framing
module spibf_master (
   output logic      sclk_out,
   output logic      cs_n_out,
   output logic      mosi_out,
   input  wire logic miso_in
);
   localparam realtime HALF = 62.5;

   initial begin
      sclk_out = 1'b0;
      cs_n_out = 1'b1;
      mosi_out = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // select change with clock idle
   task automatic frame(input logic on);
      #(2 * HALF);
      cs_n_out = ~on;
      #(2 * HALF);
   endtask

   task automatic xfer(input logic [7:0] tx, input logic lsb,
                       output logic [7:0] rx);
      int k;
      for (int i = 0; i < 8; i++) begin
         k = lsb ? i : 7 - i;
         mosi_out = tx[k];
         #HALF;
         sclk_out = 1'b1;
         rx[k] = miso_in;
         #HALF;
         sclk_out = 1'b0;
      end
      // Stale data line once the hold has run out
      mosi_out = ~tx[k];
      #(2 * HALF);
   endtask
endmodule

// ### bench/testbench.sv
`timescale 1ns/1ps
module testbench;
   logic                     clk_sys_in, rst_in, ce_in, enable_in;
   logic                     lsb_sel, rx_irq_enable, tx_irq_enable, go_set, go, irq;
   logic                     sclk, cs_n, mosi, miso, miso_oe_n;
   spibf_pkg::spibf_req_type req;
   spibf_pkg::spibf_mem_type mem_bus;
   logic [7:0]               rdata, mem_rdata, got, v, txb, rxb;
   logic [7:0]               d [4];
   logic [7:0]               sent [257];
   logic [7:0]               mem [4096];
   int                       mismatches, compares, n;

   spibf_core u_dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
      .ce_in(ce_in), .reg_req_in(req), .reg_rdata_out(rdata),
      .enable_in(enable_in), .low_bit_first_select_in(lsb_sel),
      .rx_irq_enable_in(rx_irq_enable), .tx_irq_enable_in(tx_irq_enable),
      .fast_transfer_go_set_in(go_set), .fast_transfer_go_out(go),
      .sclk_in(sclk), .cs_n_in(cs_n), .mosi_in(mosi), .miso_out(miso),
      .miso_oe_n_out(miso_oe_n), .mem_out(mem_bus),
      .mem_rdata_in(mem_rdata), .irq_out(irq));

   spibf_master u_master (.sclk_out(sclk), .cs_n_out(cs_n),
      .mosi_out(mosi), .miso_in(miso_oe_n ? ~miso : miso));

   initial begin
      clk_sys_in = 1'b0;
      forever #5 clk_sys_in = ~clk_sys_in;
   end

   // Memory read straight from the registered address
   always @(posedge clk_sys_in) begin
      if (mem_bus.wr)
         mem[mem_bus.addr] <= mem_bus.wdata;
   end
   assign mem_rdata = mem[mem_bus.addr];

   ////////////////////////////////////////////////////////////////////////
   task automatic close_out;
      $display("counts: %0d compares %0d mismatches", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic check(input logic [7:0] seen, exp, input string what);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %0t %s seen %h want %h", $time, what, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, x);
      @(posedge clk_sys_in);
      req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: x};
      @(posedge clk_sys_in);
      req.wr <= 1'b0;
   endtask

   task automatic chk(input logic [7:0] a, exp, input string what);
      @(posedge clk_sys_in);
      req.addr <= a;
      @(posedge clk_sys_in);
      #1 check(rdata, exp, what);
   endtask

   function automatic logic [7:0] irq_exp(logic [7:0] st, logic ri, ti);
      return {7'h0, (st[spibf_pkg::BIT_RX_FULL] & ri) |
                    (st[spibf_pkg::BIT_TX_EMPTY] & ti)};
   endfunction

   function automatic logic [11:0] fa(logic [7:0] b, int i);
      return ({4'h0, b} << spibf_pkg::BASE_SHIFT) + 12'(i);
   endfunction

   task automatic irq_sweep(input logic [7:0] st);
      for (int m = 0; m < 4; m++) begin
         @(posedge clk_sys_in);
         rx_irq_enable <= m[0];
         tx_irq_enable <= m[1];
         repeat (3) @(posedge clk_sys_in);
         #1 check({7'h0, irq}, irq_exp(st, m[0], m[1]), "irq");
      end
   endtask

   task automatic xch(input logic [7:0] tx, exp);
      u_master.xfer(tx, lsb_sel, got);
      check(got, exp, "miso byte");
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      #900us;
      mismatches++;
      $display("BAD %0t run too long", $time);
      close_out();
   end

   initial begin
      void'($urandom(71));
      req = '0;
      rst_in = 1'b1;
      ce_in = 1'b1;
      enable_in = 1'b1;
      lsb_sel = 1'b0;
      rx_irq_enable = 1'b0;
      tx_irq_enable = 1'b0;
      go_set = 1'b0;
      repeat (5) @(posedge clk_sys_in);
      rst_in <= 1'b0;
      chk(spibf_pkg::OFF_TX_BASE, 8'h00, "rst tx base");
      chk(spibf_pkg::OFF_RX_BASE, 8'h00, "rst rx base");
      chk(spibf_pkg::OFF_COUNT_LOW, 8'h00, "rst count lo");
      chk(spibf_pkg::OFF_COUNT_HIGH, 8'h00, "rst count hi");
      chk(spibf_pkg::OFF_DATA, 8'h00, "rst data");
      chk(spibf_pkg::OFF_STATE, 8'h01, "rst state");
      chk(8'h55, 8'h00, "unmapped");
      for (int i = 0; i < 4; i++) begin
         v = (i == 3) ? 8'($urandom_range(15)) : 8'($urandom);
         wr(spibf_pkg::OFF_TX_BASE + 8'(i), v);
         chk(spibf_pkg::OFF_TX_BASE + 8'(i), v, "rw");
      end
      ce_in <= 1'b0;
      wr(spibf_pkg::OFF_COUNT_HIGH, ~v);
      ce_in <= 1'b1;
      chk(spibf_pkg::OFF_COUNT_HIGH, v, "frozen");
      $display("test registers done");

      for (int i = 0; i < 4; i++)
         d[i] = 8'($urandom);
      u_master.frame(1'b1);
      check({7'h0, miso_oe_n}, 8'h00, "miso drive");
      wr(spibf_pkg::OFF_DATA, d[0]);
      chk(spibf_pkg::OFF_STATE, 8'h01, "first write");
      wr(spibf_pkg::OFF_DATA, d[1]);
      chk(spibf_pkg::OFF_STATE, 8'h00, "second write");
      xch(d[3], d[0]);
      chk(spibf_pkg::OFF_STATE, 8'h05, "rx full");
      chk(spibf_pkg::OFF_DATA, d[3], "rx data");
      irq_sweep(8'h05);
      wr(spibf_pkg::OFF_DATA, d[2]);
      chk(spibf_pkg::OFF_STATE, 8'h04, "tx queued");
      irq_sweep(8'h04);
      xch(~d[3], d[1]);
      chk(spibf_pkg::OFF_STATE, 8'h07, "overrun");
      chk(spibf_pkg::OFF_DATA, d[3], "old byte kept");
      wr(spibf_pkg::OFF_STATE, 8'h07);
      chk(spibf_pkg::OFF_STATE, 8'h07, "ones keep");
      wr(spibf_pkg::OFF_STATE, 8'h01);
      chk(spibf_pkg::OFF_STATE, 8'h01, "zero clears");
      xch(d[1], d[2]);
      chk(spibf_pkg::OFF_DATA, d[1], "third byte");
      u_master.frame(1'b0);
      check({7'h0, miso_oe_n}, 8'h01, "miso released");
      wr(spibf_pkg::OFF_STATE, 8'h01);
      $display("test normal mode done");

      @(posedge clk_sys_in);
      lsb_sel <= 1'b1;
      txb = 8'($urandom_range(111));
      rxb = txb + 8'h80;
      for (int i = 0; i < 4096; i++)
         mem[i] = 8'($urandom);
      wr(spibf_pkg::OFF_TX_BASE, txb);
      wr(spibf_pkg::OFF_RX_BASE, rxb);
      wr(spibf_pkg::OFF_COUNT_LOW, 8'h01);
      wr(spibf_pkg::OFF_COUNT_HIGH, 8'hf1);
      @(posedge clk_sys_in);
      go_set <= 1'b1;
      @(posedge clk_sys_in);
      go_set <= 1'b0;
      repeat (3) @(posedge clk_sys_in);
      #1 check({7'h0, go}, 8'h01, "go set");
      u_master.frame(1'b1);
      for (int i = 0; i < 257; i++) begin
         sent[i] = 8'($urandom);
         u_master.xfer(sent[i], 1'b1, got);
         check(got, mem[fa(txb, i)], "fast tx");
         if (i < 256)
            check({7'h0, go}, 8'h01, "go early");
      end
      for (n = 0; n < 50 && go !== 1'b0; n++)
         @(posedge clk_sys_in) #1;
      check({7'h0, go}, 8'h00, "go end");
      u_master.frame(1'b0);
      for (int i = 0; i < 257; i++)
         check(mem[fa(rxb, i)], sent[i], "fast rx");
      chk(spibf_pkg::OFF_STATE, 8'h05, "fast end");
      irq_sweep(8'h05);
      $display("test fast mode done");
      close_out();
   end
endmodule

// ### rtl/spibf_core.sv
`timescale 1ns/1ps
module spibf_core #(
   parameter int ADDR_W = 12
) (
   input  wire logic                   clk_sys_in,
   input  wire logic                   rst_in,
   input  wire logic                   ce_in,
   input  wire spibf_pkg::spibf_req_type reg_req_in,
   output logic [7:0]                  reg_rdata_out,
   input  wire logic                   enable_in,
   input  wire logic                   low_bit_first_select_in,
   input  wire logic                   rx_irq_enable_in,
   input  wire logic                   tx_irq_enable_in,
   input  wire logic                   fast_transfer_go_set_in,
   output logic                        fast_transfer_go_out,
   input  wire logic                   sclk_in,
   input  wire logic                   cs_n_in,
   input  wire logic                   mosi_in,
   output logic                        miso_out,
   output logic                        miso_oe_n_out,
   output spibf_pkg::spibf_mem_type    mem_out,
   input  wire logic [7:0]             mem_rdata_in,
   output logic                        irq_out
);
   if (ADDR_W < 12) begin : g_addr_check
      $error("ADDR_W must cover base pointers and count");
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   logic [2:0] s1_reg, s1_next;
   logic [2:0] s2_reg, s2_next;
   logic       sclk_old_reg, sclk_old_next;
   always_comb begin
      s1_next       = {sclk_in, cs_n_in, mosi_in};
      s2_next       = s1_reg;
      sclk_old_next = s2_reg[2];
   end
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         s1_reg       <= spibf_pkg::RST_PINS;
         s2_reg       <= spibf_pkg::RST_PINS;
         sclk_old_reg <= spibf_pkg::RST_PINS[2];
      end else if (ce_in) begin
         s1_reg       <= s1_next;
         s2_reg       <= s2_next;
         sclk_old_reg <= sclk_old_next;
      end
   end
   logic sclk_rise, sclk_fall, cs_n_s, mosi_s;
   assign sclk_rise = s2_reg[2] & ~sclk_old_reg;
   assign sclk_fall = ~s2_reg[2] & sclk_old_reg;
   assign cs_n_s    = s2_reg[1];
   assign mosi_s    = s2_reg[0];

   ////////////////////////////////////////////////////////////////////////
   // Registers, flags and shifter
   function automatic logic [ADDR_W-1:0] base_addr(input logic [7:0] b);
      base_addr = ADDR_W'(b) << spibf_pkg::BASE_SHIFT;
   endfunction

   logic [7:0]  txb_reg, txb_next, rxb_reg, rxb_next;
   logic [7:0]  cnt_lo_reg, cnt_lo_next;
   logic [3:0]  cnt_hi_reg, cnt_hi_next;
   logic [7:0]  rxh_reg, rxh_next, txh_reg, txh_next;
   logic [7:0]  sh_reg, sh_next;
   logic [3:0]  bit_reg, bit_next;
   logic        busy_reg, busy_next, txh_full_reg, txh_full_next;
   logic        txe_reg, txe_next, rxf_reg, rxf_next, ovr_reg, ovr_next;
   logic        go_reg, go_next;
   logic [11:0] done_reg, done_next;
   logic [ADDR_W-1:0] tp_reg, tp_next, rp_reg, rp_next;
   spibf_pkg::spibf_state_type st_reg, st_next;
   spibf_pkg::spibf_mem_type   mem_reg, mem_next;
   logic [7:0]  rd_reg, rd_next;
   logic        miso_reg, miso_next, irq_reg, irq_next;
   logic        byte_end;
   logic [7:0]  rx_byte;
   logic [11:0] fast_count;

   assign fast_count = {cnt_hi_reg, cnt_lo_reg};
   assign rx_byte = low_bit_first_select_in ? {mosi_s, sh_reg[7:1]}
                                            : {sh_reg[6:0], mosi_s};
   assign byte_end = sclk_rise & ~cs_n_s & (bit_reg == spibf_pkg::BIT_LAST);

   always_comb begin
      txb_next      = txb_reg;
      rxb_next      = rxb_reg;
      cnt_lo_next   = cnt_lo_reg;
      cnt_hi_next   = cnt_hi_reg;
      rxh_next      = rxh_reg;
      txh_next      = txh_reg;
      sh_next       = sh_reg;
      bit_next      = bit_reg;
      busy_next     = busy_reg;
      txh_full_next = txh_full_reg;
      txe_next      = txe_reg;
      rxf_next      = rxf_reg;
      ovr_next      = ovr_reg;
      go_next       = go_reg;
      done_next     = done_reg;
      tp_next       = tp_reg;
      rp_next       = rp_reg;
      st_next       = st_reg;
      mem_next      = '0;
      miso_next     = miso_reg;
      rd_next       = rd_reg;
      // Register writes
      if (reg_req_in.wr) begin
         unique case (reg_req_in.addr)
            spibf_pkg::OFF_TX_BASE:    txb_next = reg_req_in.wdata;
            spibf_pkg::OFF_RX_BASE:    rxb_next = reg_req_in.wdata;
            spibf_pkg::OFF_COUNT_LOW:  cnt_lo_next = reg_req_in.wdata;
            spibf_pkg::OFF_COUNT_HIGH:
               cnt_hi_next = reg_req_in.wdata[spibf_pkg::COUNT_HI_W-1:0];
            spibf_pkg::OFF_DATA: begin
               if (!busy_reg && !txh_full_reg && !go_reg) begin
                  sh_next   = reg_req_in.wdata;
                  busy_next = 1'b1;
               end else begin
                  txh_next      = reg_req_in.wdata;
                  txh_full_next = 1'b1;
                  // tx empty cleared by queued write
                  txe_next      = 1'b0;
               end
            end
            spibf_pkg::OFF_STATE: begin
               // rx full cleared by zero write
               if (!reg_req_in.wdata[spibf_pkg::BIT_RX_FULL])
                  rxf_next = 1'b0;
               if (!reg_req_in.wdata[spibf_pkg::BIT_OVERRUN])
                  ovr_next = 1'b0;
            end
            default: ;
         endcase
      end
      // Fast mode start
      if (fast_transfer_go_set_in && !go_reg && enable_in) begin
         go_next   = 1'b1;
         done_next = '0;
         tp_next   = base_addr(txb_reg);
         rp_next   = base_addr(rxb_reg);
         st_next   = spibf_pkg::ST_FETCH;
         bit_next  = '0;
      end
      // Serial bit engine
      if (cs_n_s) begin
         bit_next = '0;
      end else if (sclk_rise) begin
         sh_next  = rx_byte;
         bit_next = bit_reg + 4'h1;
      end
      // first bit stands before first clock
      if (bit_reg == '0 || sclk_fall)
         miso_next = low_bit_first_select_in ? sh_reg[0] : sh_reg[7];
      if (byte_end) begin
         bit_next = '0;
         if (go_reg) begin
            mem_next.wr    = 1'b1;
            mem_next.addr  = 12'(rp_reg);
            mem_next.wdata = rx_byte;
            rp_next   = rp_reg + ADDR_W'(1);
            tp_next   = tp_reg + ADDR_W'(1);
            done_next = done_reg + 12'h1;
            st_next   = spibf_pkg::ST_FETCH;
            if (done_reg + 12'h1 == fast_count) begin
               go_next  = 1'b0;
               rxf_next = 1'b1;
               txe_next = 1'b1;
               st_next  = spibf_pkg::ST_IDLE;
            end
         end else begin
            if (rxf_next)
               ovr_next = 1'b1;
            else begin
               rxh_next = rx_byte;
               rxf_next = 1'b1;
            end
            if (txh_full_next) begin
               sh_next       = txh_next;
               txh_full_next = 1'b0;
               txe_next      = 1'b1;
            end else
               busy_next = 1'b0;
         end
      end else if (go_reg && st_reg == spibf_pkg::ST_FETCH) begin
         mem_next.addr = 12'(tp_reg);
         st_next       = spibf_pkg::ST_STORE;
      end else if (go_reg && st_reg == spibf_pkg::ST_STORE) begin
         sh_next = mem_rdata_in;
         st_next = spibf_pkg::ST_SHIFT;
      end
      if (!go_reg && st_reg != spibf_pkg::ST_IDLE && !fast_transfer_go_set_in)
         st_next = spibf_pkg::ST_IDLE;
      if (!enable_in) begin
         busy_next     = 1'b0;
         txh_full_next = 1'b0;
         txe_next      = 1'b1;
      end
      // Read data path
      unique case (reg_req_in.addr)
         spibf_pkg::OFF_DATA:       rd_next = rxh_reg;
         spibf_pkg::OFF_TX_BASE:    rd_next = txb_reg;
         spibf_pkg::OFF_RX_BASE:    rd_next = rxb_reg;
         spibf_pkg::OFF_COUNT_LOW:  rd_next = cnt_lo_reg;
         spibf_pkg::OFF_COUNT_HIGH: rd_next = {4'h0, cnt_hi_reg};
         spibf_pkg::OFF_STATE:      rd_next = {5'h0, rxf_reg, ovr_reg, txe_reg};
         default:                   rd_next = 8'h00;
      endcase
   end

   always_comb irq_next = (rxf_next & rx_irq_enable_in) |
                          (txe_next & tx_irq_enable_in);

   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         txb_reg      <= spibf_pkg::RST_BYTE;
         rxb_reg      <= spibf_pkg::RST_BYTE;
         cnt_lo_reg   <= spibf_pkg::RST_BYTE;
         cnt_hi_reg   <= '0;
         rxh_reg      <= spibf_pkg::RST_BYTE;
         txh_reg      <= spibf_pkg::RST_BYTE;
         sh_reg       <= spibf_pkg::RST_BYTE;
         bit_reg      <= '0;
         busy_reg     <= 1'b0;
         txh_full_reg <= 1'b0;
         txe_reg      <= spibf_pkg::RST_STATE[spibf_pkg::BIT_TX_EMPTY];
         rxf_reg      <= 1'b0;
         ovr_reg      <= 1'b0;
         go_reg       <= 1'b0;
         done_reg     <= '0;
         tp_reg       <= '0;
         rp_reg       <= '0;
         st_reg       <= spibf_pkg::ST_IDLE;
         mem_reg      <= '0;
         miso_reg     <= 1'b0;
         rd_reg       <= spibf_pkg::RST_BYTE;
         irq_reg      <= 1'b0;
      end else if (ce_in) begin
         txb_reg      <= txb_next;
         rxb_reg      <= rxb_next;
         cnt_lo_reg   <= cnt_lo_next;
         cnt_hi_reg   <= cnt_hi_next;
         rxh_reg      <= rxh_next;
         txh_reg      <= txh_next;
         sh_reg       <= sh_next;
         bit_reg      <= bit_next;
         busy_reg     <= busy_next;
         txh_full_reg <= txh_full_next;
         txe_reg      <= txe_next;
         rxf_reg      <= rxf_next;
         ovr_reg      <= ovr_next;
         go_reg       <= go_next;
         done_reg     <= done_next;
         tp_reg       <= tp_next;
         rp_reg       <= rp_next;
         st_reg       <= st_next;
         mem_reg      <= mem_next;
         miso_reg     <= miso_next;
         rd_reg       <= rd_next;
         irq_reg      <= irq_next;
      end
   end

   assign reg_rdata_out        = rd_reg;
   assign fast_transfer_go_out = go_reg;
   assign miso_out             = miso_reg;
   assign miso_oe_n_out        = s2_reg[1];
   assign mem_out              = mem_reg;
   assign irq_out              = irq_reg;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   // queued data write (shifter busy, tx holding full or fast mode on) clears tx empty flag
   property p_txe_clear;
      @(posedge clk_sys_in) disable iff (rst_in)
      (ce_in && enable_in && reg_req_in.wr
       && (busy_reg || txh_full_reg || go_reg)
       && reg_req_in.addr == spibf_pkg::OFF_DATA && !byte_end) |=> !txe_reg;
   endproperty
   a_txe_clear: assert property (p_txe_clear)
      else $error("tx empty not cleared by data write");

   property p_irq;
      @(posedge clk_sys_in) disable iff (rst_in)
      ce_in |=> irq_reg == ((rxf_reg & $past(rx_irq_enable_in)) |
                            (txe_reg & $past(tx_irq_enable_in)));
   endproperty
   a_irq: assert property (p_irq)
      else $error("irq does not follow flags and enables");

   property p_rxf_hold;
      @(posedge clk_sys_in) disable iff (rst_in)
      (ce_in && rxf_reg && !(reg_req_in.wr &&
       reg_req_in.addr == spibf_pkg::OFF_STATE)) |=> rxf_reg;
   endproperty
   a_rxf_hold: assert property (p_rxf_hold)
      else $error("rx full dropped without software clear");

   property p_overrun_keeps;
      @(posedge clk_sys_in) disable iff (rst_in)
      (ce_in && byte_end && !go_reg && rxf_reg && !(reg_req_in.wr
       && reg_req_in.addr == spibf_pkg::OFF_STATE)) |=>
         (ovr_reg && $stable(rxh_reg));
   endproperty
   a_overrun_keeps: assert property (p_overrun_keeps)
      else $error("overrun did not keep old byte");

   property p_fast_start;
      @(posedge clk_sys_in) disable iff (rst_in)
      (ce_in && fast_transfer_go_set_in && !go_reg && enable_in) |=>
         (tp_reg == (ADDR_W'($past(txb_reg)) << spibf_pkg::BASE_SHIFT)
          && rp_reg == (ADDR_W'($past(rxb_reg)) << spibf_pkg::BASE_SHIFT));
   endproperty
   a_fast_start: assert property (p_fast_start)
      else $error("fast start pointers wrong");

   property p_fast_end;
      @(posedge clk_sys_in) disable iff (rst_in)
      (ce_in && byte_end && go_reg && done_reg + 12'h1 == fast_count) |=>
         (!go_reg && rxf_reg && txe_reg);
   endproperty
   a_fast_end: assert property (p_fast_end)
      else $error("fast transfer did not end at count");

   property p_store;
      @(posedge clk_sys_in) disable iff (rst_in)
      (ce_in && byte_end && go_reg) |=>
         (mem_reg.wr && mem_reg.addr == $past(rp_reg)
          && rp_reg == $past(rp_reg) + ADDR_W'(1));
   endproperty
   a_store: assert property (p_store)
      else $error("received byte not stored or pointer not stepped");

   property p_idle_load;
      @(posedge clk_sys_in) disable iff (rst_in)
      (ce_in && enable_in && reg_req_in.wr && !busy_reg && !txh_full_reg
       && !go_reg && reg_req_in.addr == spibf_pkg::OFF_DATA) |=>
         (busy_reg && !txh_full_reg);
   endproperty
   a_idle_load: assert property (p_idle_load)
      else $error("idle write did not go to shifter");
endmodule

// ### rtl/spibf_pkg.sv
package spibf_pkg;
   // Register offsets on the documented register port
   localparam logic [7:0] OFF_TX_BASE    = 8'h3e;
   localparam logic [7:0] OFF_RX_BASE    = 8'h3f;
   localparam logic [7:0] OFF_COUNT_LOW  = 8'h40;
   localparam logic [7:0] OFF_COUNT_HIGH = 8'h41;
   localparam logic [7:0] OFF_DATA       = 8'hbf;
   localparam logic [7:0] OFF_STATE      = 8'hbe;
   // Status field positions
   localparam int BIT_TX_EMPTY = 0;
   localparam int BIT_OVERRUN  = 1;
   localparam int BIT_RX_FULL  = 2;
   // Reset values
   localparam logic [7:0] RST_BYTE  = 8'h00;
   localparam logic [2:0] RST_STATE = 3'h1;
   localparam logic [2:0] RST_PINS  = 3'h6;
   // Base pointers count in 16-byte units
   localparam int BASE_SHIFT = 4;
   localparam int COUNT_HI_W = 4;
   localparam int BITS_BYTE  = 8;
   localparam logic [3:0] BIT_LAST = 4'h7;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } spibf_req_type;

   typedef struct packed {
      logic        wr;
      logic [11:0] addr;
      logic [7:0]  wdata;
   } spibf_mem_type;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_FETCH = 2'b01,
      ST_SHIFT = 2'b11,
      ST_STORE = 2'b10
   } spibf_state_type;
endpackage
